// file: common/ptp_time_pkg.sv
// shared constants for the ptp system-time unit
package ptp_time_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SUBSEC_INC = 8'h04;
   localparam logic [7:0] OFS_ADDEND = 8'h08;
   localparam logic [7:0] OFS_TIME_SEC = 8'h0c;
   localparam logic [7:0] OFS_TIME_SUB = 8'h10;
   // control register fields
   localparam int CTL_ENABLE = 0;
   localparam int CTL_PTP_V2 = 1;
   localparam int CTL_DECIMAL = 2;
   localparam int CTL_DEST_FILT = 3;
   localparam int CTL_FINE = 4;
   localparam int CTL_SUBSET_ON = 5;
   localparam int CTL_SEL_LSB = 8;
   localparam int CTL_UDP_V4 = 12;
   localparam int CTL_UDP_V6 = 13;
   localparam int CTL_RAW_L2 = 14;
   localparam int CTL_EVERY_RX = 15;
   localparam logic [31:0] CTRL_MASK = 32'h0000_f73f;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] SUBSEC_INC_RST = 32'h0000_0000;
   localparam logic [31:0] ADDEND_RST = 32'h0000_0000;
   // subsecond wrap points
   localparam logic [31:0] DECIMAL_MAX = 32'h3ba9_c9ff;
   localparam logic [31:0] BINARY_MAX = 32'h7fff_ffff;
   // frame encapsulation codes from the mac parser
   localparam logic [1:0] ENC_NONE = 2'h0;
   localparam logic [1:0] ENC_RAW_L2 = 2'h1;
   localparam logic [1:0] ENC_UDP_V4 = 2'h2;
   localparam logic [1:0] ENC_UDP_V6 = 2'h3;
   // ptp message type codes and versions
   localparam logic [3:0] MSG_SYNC = 4'h0;
   localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
   localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
   localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;
   localparam logic [3:0] MSG_FOLLOW_UP = 4'h8;
   localparam logic [3:0] MSG_DELAY_RESP = 4'h9;
   localparam logic [3:0] PTP_VER1 = 4'h1;
   localparam logic [3:0] PTP_VER2 = 4'h2;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // one-of message subset selection
   typedef enum logic [2:0] {
      SEL_SYNC_FOLLOWUP_DELAY, SEL_SYNC_MSGS, SEL_DELAY_REQUEST_MSGS,
      SEL_EVERY_PTP_MSG, SEL_SYNC_PEER_DELAY, SEL_DELAY_REQ_PEER_DELAY,
      SEL_SYNC_DELAY_REQ, SEL_PEER_DELAY_MSGS
   } msg_sel_e;
   // merge write data into a register under byte strobes
   function automatic logic [31:0] apply_wstrb(input logic [31:0] old,
         input logic [31:0] wd, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// file: hw/ptp_sys_time.sv
// seconds and subseconds counter with addend accumulator
`timescale 1ns/10ps
`default_nettype none
module ptp_sys_time
   import ptp_time_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic fine_i,
   input wire logic decimal_i,
   input wire logic [31:0] incr_i,
   input wire logic [31:0] addend_i,
   input wire logic load_sec_i,
   input wire logic load_sub_i,
   input wire logic [31:0] load_val_i,
   output logic [31:0] sec_o,
   output logic [31:0] sub_o
);
   logic [31:0] acc_q, sub_q, sec_q;
   logic [32:0] acc_sum, sub_sum, wrap_lim, sub_red;
   logic tick, wrap;

   // tick every cycle when coarse, on accumulator carry when fine
   always_comb begin
      acc_sum = {1'b0, acc_q} + {1'b0, addend_i};
      sub_sum = {1'b0, sub_q} + {1'b0, incr_i};
      wrap_lim = {1'b0, decimal_i ? DECIMAL_MAX : BINARY_MAX} + 33'h1;
      sub_red = sub_sum - wrap_lim;
      tick = run_i && (fine_i ? acc_sum[32] : 1'b1);
      wrap = sub_sum >= wrap_lim;
   end

   // accumulator only moves while running in fine mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= 32'h0;
      end else if (run_i && fine_i) begin
         acc_q <= acc_sum[31:0];
      end
   end

   // subseconds keep the remainder past the wrap, so exact steps land on 0
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_q <= 32'h0;
      end else if (load_sub_i) begin
         sub_q <= load_val_i;
      end else if (tick) begin
         sub_q <= wrap ? sub_red[31:0] : sub_sum[31:0];
      end
   end

   // seconds step once per subsecond wrap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec_q <= 32'h0;
      end else if (load_sec_i) begin
         sec_q <= load_val_i;
      end else if (tick && wrap) begin
         sec_q <= sec_q + 32'h1;
      end
   end

   assign sec_o = sec_q;
   assign sub_o = sub_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_dec_wrap;
      tick && decimal_i && !load_sub_i
         && sub_sum == {1'b0, DECIMAL_MAX} + 33'h1
         |=> sub_q == 32'h0;
   endproperty
   a_dec_wrap: assert property (p_dec_wrap)
      else $error("decimal subsecond did not wrap to zero");
   property p_bin_wrap;
      tick && !decimal_i && !load_sub_i && sub_sum == 33'h0_8000_0000
         |=> sub_q == 32'h0;
   endproperty
   a_bin_wrap: assert property (p_bin_wrap)
      else $error("binary subsecond did not wrap to zero");
   property p_sec_step;
      tick && wrap && !load_sec_i |=> sec_q == $past(sec_q) + 32'h1;
   endproperty
   a_sec_step: assert property (p_sec_step)
      else $error("seconds did not step on wrap");
   property p_coarse;
      run_i && !fine_i && !load_sub_i && !wrap
         |=> sub_q == $past(sub_q) + $past(incr_i);
   endproperty
   a_coarse: assert property (p_coarse)
      else $error("coarse mode missed an increment");
   property p_fine_hold;
      run_i && fine_i && !acc_sum[32] && !load_sub_i |=> $stable(sub_q);
   endproperty
   a_fine_hold: assert property (p_fine_hold)
      else $error("fine mode moved without a carry");
   property p_stopped;
      !run_i && !load_sub_i && !load_sec_i
         |=> $stable(sub_q) && $stable(sec_q) && $stable(acc_q);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("time moved while disabled");
   c_sec_wrap: cover property (tick && wrap);
endmodule
`default_nettype wire

// file: hw/ptp_frame_filter.sv
// decides whether a received frame gets a timestamp
`timescale 1ns/10ps
`default_nettype none
module ptp_frame_filter
   import ptp_time_pkg::*;
(
   input wire logic [31:0] ctrl_i,
   input wire logic is_ptp_i,
   input wire logic [1:0] encap_i,
   input wire logic [3:0] ver_i,
   input wire logic [3:0] msg_i,
   input wire logic dest_match_i,
   output logic stamp_ok_o
);
   // membership of a message code in a one-of subset
   function automatic logic msg_in_sel(input msg_sel_e sel,
         input logic [3:0] m);
      logic sy, dq, pd, fu;
      sy = (m == MSG_SYNC);
      dq = (m == MSG_DELAY_REQ);
      pd = (m == MSG_PDELAY_REQ) || (m == MSG_PDELAY_RESP);
      fu = (m == MSG_FOLLOW_UP) || (m == MSG_DELAY_RESP);
      case (sel)
         SEL_SYNC_FOLLOWUP_DELAY: return sy || dq || fu;
         SEL_SYNC_MSGS: return sy;
         SEL_DELAY_REQUEST_MSGS: return dq;
         SEL_EVERY_PTP_MSG: return 1'b1;
         SEL_SYNC_PEER_DELAY: return sy || pd;
         SEL_DELAY_REQ_PEER_DELAY: return dq || pd;
         SEL_SYNC_DELAY_REQ: return dq;
         SEL_PEER_DELAY_MSGS: return pd;
         default: return 1'b0;
      endcase
   endfunction

   logic enc_ok, ver_ok, dest_ok, msg_ok;
   msg_sel_e sel;

   // each encapsulation gated by its own option
   always_comb begin
      sel = msg_sel_e'(ctrl_i[CTL_SEL_LSB +: 3]);
      case (encap_i)
         ENC_RAW_L2: enc_ok = ctrl_i[CTL_RAW_L2];
         ENC_UDP_V4: enc_ok = ctrl_i[CTL_UDP_V4];
         ENC_UDP_V6: enc_ok = ctrl_i[CTL_UDP_V6];
         default: enc_ok = 1'b0;
      endcase
      ver_ok = ver_i == (ctrl_i[CTL_PTP_V2] ? PTP_VER2 : PTP_VER1);
      dest_ok = !ctrl_i[CTL_DEST_FILT] || dest_match_i;
      // no subset chosen falls back to the sync/delay four
      msg_ok = ctrl_i[CTL_SUBSET_ON] ? msg_in_sel(sel, msg_i)
         : msg_in_sel(SEL_SYNC_FOLLOWUP_DELAY, msg_i);
      stamp_ok_o = ctrl_i[CTL_ENABLE] && (is_ptp_i
         ? (enc_ok && ver_ok && dest_ok && msg_ok)
         : ctrl_i[CTL_EVERY_RX]);
   end
endmodule
`default_nettype wire

// file: hw/ptp_timestamp_clock_config.sv
// ptp system-time unit: axi4-lite registers, time counter, stamps
`timescale 1ns/10ps
`default_nettype none
module ptp_timestamp_clock_config
   import ptp_time_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic RX_FRAME_VALID_I,
   input wire logic RX_IS_PTP_I,
   input wire logic [1:0] RX_ENCAP_I,
   input wire logic [3:0] RX_PTP_VER_I,
   input wire logic [3:0] RX_MSG_TYPE_I,
   input wire logic RX_DEST_MATCH_I,
   input wire logic TX_STAMP_REQ_I,
   output logic RX_STAMP_VALID_O,
   output logic [31:0] RX_STAMP_SEC_O,
   output logic [31:0] RX_STAMP_SUB_O,
   output logic TX_STAMP_VALID_O,
   output logic [31:0] TX_STAMP_SEC_O,
   output logic [31:0] TX_STAMP_SUB_O,
   output logic [31:0] TIME_SEC_O,
   output logic [31:0] TIME_SUB_O
);
   // true for the byte offsets that hold a register
   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFS_CTRL || a == OFS_SUBSEC_INC || a == OFS_ADDEND
         || a == OFS_TIME_SEC || a == OFS_TIME_SUB;
   endfunction

   logic rst_meta_n_q, rst_n_q;
   logic awready_q, aw_full_q, wready_q, w_full_q;
   logic arready_q, ar_full_q, bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [31:0] ctrl_q, incr_q, addend_q;
   logic [31:0] sec_now, sub_now, load_val;
   logic wr_fire, load_sec, load_sub, stamp_ok;
   logic rx_vld_q, tx_vld_q;
   logic [31:0] rx_sec_q, rx_sub_q, tx_sec_q, tx_sub_q;

   // reset released through two flops; assertion is still immediate
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rst_meta_n_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_n_q <= 1'b1;
         rst_n_q <= rst_meta_n_q;
      end
   end

   // write address channel, one write outstanding at a time
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (AWVALID_I && awready_q) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b1;
         awaddr_q <= AWADDR_I;
      end else if (bvalid_q && BREADY_I) begin
         awready_q <= 1'b1;
         aw_full_q <= 1'b0;
      end else begin
         awready_q <= !aw_full_q;
      end
   end

   // write data channel, taken independently of the address
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wready_q <= 1'b0;
         w_full_q <= 1'b0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else if (WVALID_I && wready_q) begin
         wready_q <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q <= WDATA_I;
         wstrb_q <= WSTRB_I;
      end else if (bvalid_q && BREADY_I) begin
         wready_q <= 1'b1;
         w_full_q <= 1'b0;
      end else begin
         wready_q <= !w_full_q;
      end
   end

   // both halves held and no answer pending: commit the write
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign load_sec = wr_fire && awaddr_q == OFS_TIME_SEC;
   assign load_sub = wr_fire && awaddr_q == OFS_TIME_SUB;
   assign load_val = apply_wstrb(load_sec ? sec_now : sub_now,
      wdata_q, wstrb_q);

   // write response; unmapped offsets answer slverr and change nothing
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
         bvalid_q <= 1'b0;
      end
   end

   // configuration registers written by software
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= CTRL_RST;
         incr_q <= SUBSEC_INC_RST;
         addend_q <= ADDEND_RST;
      end else if (wr_fire) begin
         case (awaddr_q)
            OFS_CTRL: ctrl_q <= apply_wstrb(ctrl_q, wdata_q, wstrb_q)
               & CTRL_MASK;
            OFS_SUBSEC_INC: incr_q <= apply_wstrb(incr_q, wdata_q, wstrb_q);
            OFS_ADDEND: addend_q <= apply_wstrb(addend_q, wdata_q, wstrb_q);
            default: ;
         endcase
      end
   end

   // read channel; data and answer come one cycle after the address
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         arready_q <= 1'b0;
         ar_full_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end else if (ARVALID_I && arready_q) begin
         arready_q <= 1'b0;
         ar_full_q <= 1'b1;
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
         case (ARADDR_I)
            OFS_CTRL: rdata_q <= ctrl_q;
            OFS_SUBSEC_INC: rdata_q <= incr_q;
            OFS_ADDEND: rdata_q <= addend_q;
            OFS_TIME_SEC: rdata_q <= sec_now;
            OFS_TIME_SUB: rdata_q <= sub_now;
            default: rdata_q <= 32'h0;
         endcase
      end else if (rvalid_q && RREADY_I) begin
         arready_q <= 1'b1;
         ar_full_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else begin
         arready_q <= !ar_full_q;
      end
   end

   // the time base itself
   ptp_sys_time u_time (
      .clk_i(CLK_SYS_I),
      .rst_n_i(rst_n_q),
      .run_i(ctrl_q[CTL_ENABLE]),
      .fine_i(ctrl_q[CTL_FINE]),
      .decimal_i(ctrl_q[CTL_DECIMAL]),
      .incr_i(incr_q),
      .addend_i(addend_q),
      .load_sec_i(load_sec),
      .load_sub_i(load_sub),
      .load_val_i(load_val),
      .sec_o(sec_now),
      .sub_o(sub_now)
   );

   // receive frame classification
   ptp_frame_filter u_filter (
      .ctrl_i(ctrl_q),
      .is_ptp_i(RX_IS_PTP_I),
      .encap_i(RX_ENCAP_I),
      .ver_i(RX_PTP_VER_I),
      .msg_i(RX_MSG_TYPE_I),
      .dest_match_i(RX_DEST_MATCH_I),
      .stamp_ok_o(stamp_ok)
   );

   // receive stamp captures the time of the frame's valid cycle
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_vld_q <= 1'b0;
         rx_sec_q <= 32'h0;
         rx_sub_q <= 32'h0;
      end else begin
         rx_vld_q <= RX_FRAME_VALID_I && stamp_ok;
         if (RX_FRAME_VALID_I && stamp_ok) begin
            rx_sec_q <= sec_now;
            rx_sub_q <= sub_now;
         end
      end
   end

   // transmit stamp on request, only while the unit runs
   always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_vld_q <= 1'b0;
         tx_sec_q <= 32'h0;
         tx_sub_q <= 32'h0;
      end else begin
         tx_vld_q <= TX_STAMP_REQ_I && ctrl_q[CTL_ENABLE];
         if (TX_STAMP_REQ_I && ctrl_q[CTL_ENABLE]) begin
            tx_sec_q <= sec_now;
            tx_sub_q <= sub_now;
         end
      end
   end

   assign AWREADY_O = awready_q;
   assign WREADY_O = wready_q;
   assign BVALID_O = bvalid_q;
   assign BRESP_O = bresp_q;
   assign ARREADY_O = arready_q;
   assign RVALID_O = rvalid_q;
   assign RRESP_O = rresp_q;
   assign RDATA_O = rdata_q;
   assign RX_STAMP_VALID_O = rx_vld_q;
   assign RX_STAMP_SEC_O = rx_sec_q;
   assign RX_STAMP_SUB_O = rx_sub_q;
   assign TX_STAMP_VALID_O = tx_vld_q;
   assign TX_STAMP_SEC_O = tx_sec_q;
   assign TX_STAMP_SUB_O = tx_sub_q;
   // reference time straight from the counter flops
   assign TIME_SEC_O = sec_now;
   assign TIME_SUB_O = sub_now;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!rst_n_q);
   property p_cfg_readback;
      ARVALID_I && arready_q && ARADDR_I == OFS_CTRL
         |=> RVALID_O && RDATA_O == $past(ctrl_q);
   endproperty
   a_cfg_readback: assert property (p_cfg_readback)
      else $error("control readback mismatch");
   property p_ver_gate;
      RX_FRAME_VALID_I && RX_IS_PTP_I
         && RX_PTP_VER_I != (ctrl_q[CTL_PTP_V2] ? PTP_VER2 : PTP_VER1)
         |=> !RX_STAMP_VALID_O;
   endproperty
   a_ver_gate: assert property (p_ver_gate)
      else $error("wrong ptp version was stamped");
   property p_dest_gate;
      RX_FRAME_VALID_I && RX_IS_PTP_I && ctrl_q[CTL_DEST_FILT]
         && !RX_DEST_MATCH_I |=> !RX_STAMP_VALID_O;
   endproperty
   a_dest_gate: assert property (p_dest_gate)
      else $error("unmatched destination was stamped");
   property p_encap_gate;
      RX_FRAME_VALID_I && RX_IS_PTP_I
         && ((RX_ENCAP_I == ENC_UDP_V4 && !ctrl_q[CTL_UDP_V4])
         || (RX_ENCAP_I == ENC_UDP_V6 && !ctrl_q[CTL_UDP_V6])
         || (RX_ENCAP_I == ENC_RAW_L2 && !ctrl_q[CTL_RAW_L2]))
         |=> !RX_STAMP_VALID_O;
   endproperty
   a_encap_gate: assert property (p_encap_gate)
      else $error("disabled encapsulation was stamped");
   property p_every_rx;
      RX_FRAME_VALID_I && !RX_IS_PTP_I && ctrl_q[CTL_ENABLE]
         && ctrl_q[CTL_EVERY_RX] |=> RX_STAMP_VALID_O;
   endproperty
   a_every_rx: assert property (p_every_rx)
      else $error("frame missed with every-frame option");
   property p_default_set;
      RX_FRAME_VALID_I && RX_IS_PTP_I && !ctrl_q[CTL_SUBSET_ON]
         && (RX_MSG_TYPE_I == MSG_PDELAY_REQ
         || RX_MSG_TYPE_I == MSG_PDELAY_RESP) |=> !RX_STAMP_VALID_O;
   endproperty
   a_default_set: assert property (p_default_set)
      else $error("peer delay stamped with no subset");
   property p_sync_only;
      RX_FRAME_VALID_I && RX_IS_PTP_I && ctrl_q[CTL_SUBSET_ON]
         && ctrl_q[CTL_SEL_LSB +: 3] == 3'h1 && RX_MSG_TYPE_I != MSG_SYNC
         |=> !RX_STAMP_VALID_O;
   endproperty
   a_sync_only: assert property (p_sync_only)
      else $error("non-sync stamped in sync-only subset");
   property p_rx_time;
      RX_FRAME_VALID_I && stamp_ok |=> RX_STAMP_VALID_O
         && RX_STAMP_SEC_O == $past(sec_now)
         && RX_STAMP_SUB_O == $past(sub_now);
   endproperty
   a_rx_time: assert property (p_rx_time)
      else $error("receive stamp does not carry system time");
   property p_off_quiet;
      !ctrl_q[CTL_ENABLE] |=> !RX_STAMP_VALID_O && !TX_STAMP_VALID_O;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("stamp produced while disabled");
   c_rx_stamp: cover property (RX_FRAME_VALID_I && RX_IS_PTP_I && stamp_ok);
   c_tx_stamp: cover property (TX_STAMP_VALID_O);
   c_write: cover property (BVALID_O && BREADY_I && BRESP_O == RESP_OKAY);
endmodule
`default_nettype wire

// file: bench/mac_side_model.sv
// behavioural model of the mac receive and transmit paths
`timescale 1ns/10ps
`default_nettype none
module mac_side_model (
   input wire logic clk_i,
   output logic rx_o,
   output logic [11:0] rx_f_o,
   output logic tx_o
);
   initial {rx_o, rx_f_o, tx_o} = '0;
   // frame flags count only in the pulse cycle, so they are inverted after
   task automatic send_rx(input logic [11:0] f);
      @(posedge clk_i);
      rx_o <= 1'b1;
      rx_f_o <= f;
      @(posedge clk_i);
      rx_o <= 1'b0;
      rx_f_o <= ~f;
   endtask
   // transmit stamp request, one cycle wide
   task automatic send_tx();
      @(posedge clk_i);
      tx_o <= 1'b1;
      @(posedge clk_i);
      tx_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/test_ptp_timestamp_clock_config.sv
// self-checking bench for the ptp system-time unit
`timescale 1ns/10ps
`default_nettype none
module test_ptp_timestamp_clock_config
   import ptp_time_pkg::*;
();
   logic CLK_SYS_I, RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I;
   logic RREADY_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   logic RX_FRAME_VALID_I, RX_IS_PTP_I, RX_DEST_MATCH_I, TX_STAMP_REQ_I;
   logic RX_STAMP_VALID_O, TX_STAMP_VALID_O;
   logic [1:0] BRESP_O, RRESP_O, RX_ENCAP_I;
   logic [3:0] RX_PTP_VER_I, RX_MSG_TYPE_I, WSTRB_I;
   logic [7:0] AWADDR_I, ARADDR_I;
   logic [11:0] fr;
   logic [31:0] WDATA_I, RDATA_O, RX_STAMP_SEC_O, RX_STAMP_SUB_O, cfg;
   logic [31:0] TX_STAMP_SEC_O, TX_STAMP_SUB_O, TIME_SEC_O, TIME_SUB_O;
   logic [15:0] sel_mask [8] = '{16'h0303, 16'h0001, 16'h0002, 16'h030f,
      16'h000d, 16'h000e, 16'h0002, 16'h000c};
   logic [3:0] msgs [6] = '{MSG_SYNC, MSG_DELAY_REQ, MSG_PDELAY_REQ,
      MSG_PDELAY_RESP, MSG_FOLLOW_UP, MSG_DELAY_RESP};
   int miscompares = 0;
   int samples_checked = 0;
   assign {RX_IS_PTP_I, RX_ENCAP_I, RX_PTP_VER_I, RX_MSG_TYPE_I,
      RX_DEST_MATCH_I} = fr;
   ptp_timestamp_clock_config dut (.*);
   mac_side_model mac (.clk_i(CLK_SYS_I), .rx_o(RX_FRAME_VALID_I),
      .rx_f_o(fr), .tx_o(TX_STAMP_REQ_I));
   initial begin
      CLK_SYS_I = 1'b0;
      forever #20 CLK_SYS_I = ~CLK_SYS_I;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp({31'h0, got}, {31'h0, exp});
   endtask
   task automatic stall();
      miscompares++;
      wrap_up();
   endtask
   // bus cycles wait for the slave's answer under a bounded count
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      n = 0;
      @(posedge CLK_SYS_I);
      AWADDR_I <= a;
      WDATA_I <= d;
      {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
      do begin
         @(posedge CLK_SYS_I);
         n++;
         if (AWREADY_O) AWVALID_I <= 1'b0;
         if (WREADY_O) WVALID_I <= 1'b0;
      end while (!BVALID_O && n < 60);
      BREADY_I <= 1'b0;
      if (n >= 60) stall();
      cmp({30'h0, BRESP_O}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      int n;
      n = 0;
      @(posedge CLK_SYS_I);
      ARADDR_I <= a;
      {ARVALID_I, RREADY_I} <= 2'h3;
      do begin
         @(posedge CLK_SYS_I);
         n++;
         if (ARREADY_O) ARVALID_I <= 1'b0;
      end while (!RVALID_O && n < 60);
      RREADY_I <= 1'b0;
      if (n >= 60) stall();
      cmp(RDATA_O, ed);
      cmp({30'h0, RRESP_O}, {30'h0, er});
   endtask
   task automatic setc(input logic [31:0] c);
      cfg = c;
      wr(OFS_CTRL, c, RESP_OKAY);
   endtask
   // expected stamp decision from the control word and frame flags
   function automatic logic hit(input logic [11:0] f);
      logic [15:0] s;
      logic en;
      s = cfg[5] ? sel_mask[cfg[10:8]] : 16'h0303;
      en = f[10:9] == ENC_RAW_L2 ? cfg[14] : f[10] & cfg[12 + f[9]];
      if (!f[11]) return cfg[0] & cfg[15];
      return cfg[0] & en & s[f[4:1]] & (!cfg[3] | f[0])
         & (f[8:5] == (cfg[1] ? PTP_VER2 : PTP_VER1));
   endfunction
   // time is frozen at 5 s / 0x1234 while frames are judged
   task automatic frame(input logic [11:0] f);
      logic e;
      e = hit(f);
      mac.send_rx(f);
      @(negedge CLK_SYS_I);
      cmp1(RX_STAMP_VALID_O, e);
      if (e) begin
         cmp(RX_STAMP_SEC_O, 32'h5);
         cmp(RX_STAMP_SUB_O, 32'h1234);
      end
   endtask
   task automatic tx(input logic e);
      mac.send_tx();
      @(negedge CLK_SYS_I);
      cmp1(TX_STAMP_VALID_O, e);
      if (e) begin
         cmp(TX_STAMP_SEC_O, 32'h5);
         cmp(TX_STAMP_SUB_O, 32'h1234);
      end
   endtask
   // in fine mode a step is taken on every other cycle
   task automatic watch(input logic [31:0] inc, mx, input bit fine, int n);
      logic [31:0] ps, pc, e;
      logic add, last;
      @(negedge CLK_SYS_I);
      ps = TIME_SUB_O;
      pc = TIME_SEC_O;
      last = 1'b0;
      for (int k = 0; k < n; k++) begin
         @(negedge CLK_SYS_I);
         add = !fine || TIME_SUB_O !== ps;
         if (fine && k > 0) cmp1(add, !last);
         e = ps + (add ? inc : 32'h0);
         if (e > mx) begin
            e = e - mx - 32'h1;
            pc = pc + 32'h1;
         end
         cmp(TIME_SUB_O, e);
         cmp(TIME_SEC_O, pc);
         ps = TIME_SUB_O;
         last = add;
      end
   endtask
   initial begin
      {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
      {AWADDR_I, ARADDR_I, WDATA_I, cfg} = '0;
      WSTRB_I = 4'hf;
      RESETN_I = 1'b0;
      repeat (6) @(posedge CLK_SYS_I);
      RESETN_I <= 1'b1;
      rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
      rd(OFS_ADDEND, ADDEND_RST, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
      wr(OFS_CTRL, 32'hffff_fffe, RESP_OKAY);
      rd(OFS_CTRL, 32'hffff_fffe & CTRL_MASK, RESP_OKAY);
      // one strobed byte lane merges into the old value
      WSTRB_I <= 4'h2;
      wr(OFS_SUBSEC_INC, 32'hffff_ffff, RESP_OKAY);
      WSTRB_I <= 4'hf;
      rd(OFS_SUBSEC_INC, 32'h0000_ff00, RESP_OKAY);
      wr(OFS_SUBSEC_INC, 32'h28, RESP_OKAY);
      rd(OFS_SUBSEC_INC, 32'h28, RESP_OKAY);
      setc(32'h0000_0005);
      watch(32'h28, DECIMAL_MAX, 0, 4);
      // loads sit a whole number of steps below the wrap, so it lands on 0
      wr(OFS_TIME_SUB, DECIMAL_MAX - 32'h77, RESP_OKAY);
      watch(32'h28, DECIMAL_MAX, 0, 6);
      setc(32'h0000_0001);
      wr(OFS_TIME_SUB, BINARY_MAX - 32'h77, RESP_OKAY);
      watch(32'h28, BINARY_MAX, 0, 6);
      // half the clock rate at twice the increment keeps the 0x28 coarse rate
      wr(OFS_SUBSEC_INC, 32'h50, RESP_OKAY);
      wr(OFS_ADDEND, 32'h8000_0000, RESP_OKAY);
      setc(32'h0000_0015);
      watch(32'h50, DECIMAL_MAX, 1, 8);
      setc(32'h0000_0014);
      watch(32'h0, DECIMAL_MAX, 0, 4);
      wr(OFS_SUBSEC_INC, 32'h0, RESP_OKAY);
      wr(OFS_TIME_SEC, 32'h5, RESP_OKAY);
      wr(OFS_TIME_SUB, 32'h1234, RESP_OKAY);
      setc(32'h0000_f002);
      frame(12'h0);
      tx(1'b0);
      for (int s = 0; s < 8; s++) begin
         setc(32'h0000_7023 | (s << 8));
         foreach (msgs[i]) begin
            frame({1'b1, ENC_UDP_V4, PTP_VER2, msgs[i], 1'b0});
         end
      end
      for (int k = 0; k < 3; k++) begin
         setc(32'h0000_0323 | (32'h1000 << k));
         for (int e = 1; e < 4; e++) begin
            frame({1'b1, e[1:0], PTP_VER2, 5'h0});
         end
      end
      setc(32'h0000_7321);
      frame({1'b1, ENC_RAW_L2, PTP_VER1, 5'h0});
      frame({1'b1, ENC_RAW_L2, PTP_VER2, 5'h0});
      frame(12'h0);
      setc(32'h0000_732b);
      frame({1'b1, ENC_UDP_V6, PTP_VER2, 5'h0});
      frame({1'b1, ENC_UDP_V6, PTP_VER2, 5'h1});
      setc(32'h0000_f003);
      frame(12'h0);
      foreach (msgs[i]) begin
         frame({1'b1, ENC_UDP_V4, PTP_VER2, msgs[i], 1'b0});
      end
      tx(1'b1);
      cmp(TIME_SEC_O, 32'h5);
      wrap_up();
   end
endmodule
`default_nettype wire
